// *** pbss_host.sv ***
// controller model driving the synchronous bus of the memory port
`timescale 1ns/1ps
module pbss_host (
  // clock
  input wire logic clk_in,
  // bus toward the port
  output logic [pbss_pkg::ADDR_W-1:0] addr_out,
  output logic ps_n_out, cs_n_out, adv_n_out, pipe_n_out, hi_out, dn_out,
  output logic [pbss_pkg::LANES-1:0] lane_n_out,
  output logic wq_n_out, gw_n_out,
  output logic [pbss_pkg::DATA_W-1:0] d_out
);
  // quiet, selected bus at time zero
  initial begin
    {ps_n_out, cs_n_out, adv_n_out, pipe_n_out, hi_out, dn_out} = 6'h3a;
    {gw_n_out, wq_n_out, lane_n_out} = 6'h3f;
    addr_out = 20'h00000;
    d_out = 36'h000000000;
  end
  // one bus cycle, set up after the falling edge for the next rising edge
  task automatic drive(input logic [1:0] ld, input logic burst_advance_n, input logic [5:0] wc,
      input logic [19:0] a, input logic [35:0] d, input logic [2:0] sel);
    @(negedge clk_in);
    cs_n_out <= ld != 2'h1;
    ps_n_out <= ld != 2'h2;
    adv_n_out <= !burst_advance_n;
    {gw_n_out, wq_n_out, lane_n_out} <= wc;
    {pipe_n_out, hi_out, dn_out} <= sel;
    // lines not in use carry the inverse of their last value
    addr_out <= ld != 2'h0 ? a : ~addr_out;
    d_out <= wc != 6'h3f ? d : ~d_out;
  endtask
endmodule

// *** pbss_pkg.sv ***
// constants and types for the pipelined burst sync memory port
package pbss_pkg;

  // array geometry
  localparam int ADDR_W = 20;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // burst counter geometry
  localparam int BURST_W = 2;
  localparam int BURST_LEN = 1 << BURST_W;

  // reset values of the control state, and the all-lanes write mask
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;

  // pipeline timing: edges from address capture to data on the pins
  localparam int CLK_PERIOD_NS = 10;
  localparam int READ_LAT_CYC = 2;
  localparam int FIRST_ACCESS_CYC = READ_LAT_CYC + 1;

  // port state
  typedef enum logic [0:0] {
    PBSS_IDLE = 1'b0,
    PBSS_ACTIVE = 1'b1
  } pbss_state_e;

endpackage

// *** pbss_port.sv ***
// host port of a pipelined burst synchronous static memory, array included
`timescale 1ns/1ps

module pbss_port (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // address and strobes
  input wire logic [pbss_pkg::ADDR_W-1:0] addr_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  // chip selects
  input wire logic chip_sel_pipe_n_in,
  input wire logic chip_sel_depth_hi_in,
  input wire logic chip_sel_depth_n_in,
  // write controls and data
  input wire logic [pbss_pkg::LANES-1:0] byte_lane_write_n_in,
  input wire logic byte_write_qual_n_in,
  input wire logic all_bytes_write_n_in,
  input wire logic [pbss_pkg::DATA_W-1:0] dq_in,
  // static and asynchronous controls
  input wire logic burst_order_in,
  input wire logic out_enable_n_in,
  input wire logic sleep_request_in,
  // data pins
  output logic [pbss_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  //
  // pipeline at a glance, E being the edge at which a read is captured:
  //   edge E   : pins decoded, access stage loaded with address and intent
  //   edge E+1 : array read into the read stage, or lanes written to the array
  //   edge E+2 : read stage copied to the output register, pins show the word
  // a write and a read of the same word one edge apart see the new word,
  // because the array is updated at E+1 and read again only after that edge
  // no part of the array is reset, so a read before any write shows unknowns

  // storage array, never reset
  logic [pbss_pkg::DATA_W-1:0] mem [0:pbss_pkg::DEPTH-1];

  // burst order select pin, brought in through two flops
  logic order_meta_r;
  logic order_sync_r;

  // burst tracking state
  pbss_pkg::pbss_state_e state_r;
  pbss_pkg::pbss_state_e state_nxt;
  logic [pbss_pkg::ADDR_W-1:0] base_r;
  logic [pbss_pkg::ADDR_W-1:0] base_nxt;
  logic [pbss_pkg::BURST_W-1:0] cnt_r;
  logic [pbss_pkg::BURST_W-1:0] cnt_nxt;
  logic load_by_proc_r;
  logic load_by_proc_nxt;

  // access stage: what this edge asks of the array
  logic [pbss_pkg::ADDR_W-1:0] acc_addr_r;
  logic [pbss_pkg::ADDR_W-1:0] acc_addr_nxt;
  logic acc_rd_r;
  logic acc_rd_nxt;
  logic [pbss_pkg::LANES-1:0] acc_lanes_r;
  logic [pbss_pkg::LANES-1:0] acc_lanes_nxt;
  logic [pbss_pkg::DATA_W-1:0] acc_data_r;
  logic [pbss_pkg::DATA_W-1:0] acc_data_nxt;

  // array read stage and output stage
  logic [pbss_pkg::DATA_W-1:0] rd_data_r;
  logic [pbss_pkg::DATA_W-1:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [pbss_pkg::DATA_W-1:0] dout_r;
  logic [pbss_pkg::DATA_W-1:0] dout_nxt;
  logic dout_valid_r;
  logic dout_valid_nxt;

  // decode of the pins at this edge
  logic selected;
  logic load_proc;
  logic load_any;
  logic wr_any;
  logic [pbss_pkg::LANES-1:0] wr_lanes;
  logic [pbss_pkg::BURST_W-1:0] step_cnt;
  logic [pbss_pkg::BURST_W-1:0] low_bits;

  ////////////////////////////////////////////////////////////////////////////
  // order select synchroniser, the pin is static but arrives from outside
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      order_meta_r <= 1'b1;
      order_sync_r <= 1'b1;
    end else begin
      order_meta_r <= burst_order_in;
      order_sync_r <= order_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin decode, sleep blocks any new cycle from starting
  always_comb begin
    // all three selects must agree, sampled at the same edge as the address
    selected = ~chip_sel_pipe_n_in & chip_sel_depth_hi_in & ~chip_sel_depth_n_in;
    // the processor strobe is ignored while the pipelining select is high
    load_proc = ~proc_addr_strobe_n_in & ~chip_sel_pipe_n_in & ~sleep_request_in;
    load_any = (load_proc | ~ctrl_addr_strobe_n_in) & ~sleep_request_in;
    // all-bytes write overrides the lane selects
    if (!all_bytes_write_n_in) begin
      wr_lanes = pbss_pkg::LANES_ALL;
    end else if (!byte_write_qual_n_in) begin
      wr_lanes = ~byte_lane_write_n_in;
    end else begin
      wr_lanes = pbss_pkg::LANES_NONE;
    end
    wr_any = |wr_lanes;
    // counter steps only on advance and only within a running burst
    if (!burst_advance_n_in) begin
      step_cnt = cnt_r + 2'h1;
    end else begin
      step_cnt = cnt_r;
    end
    // low address bits: linear adds, interleaved exclusive-ors
    if (order_sync_r) begin
      low_bits = base_r[pbss_pkg::BURST_W-1:0] ^ step_cnt;
    end else begin
      low_bits = base_r[pbss_pkg::BURST_W-1:0] + step_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // notes on the burst state:
  // - a load while not selected ends a running burst at once, the single
  //   cycle deselect, so no further beat leaves the access stage after it
  // - a continue edge without advance repeats the current burst address,
  //   which lets a slow controller stretch a beat over several edges
  // - sleep ends a burst; the beats already in the pipeline still drain
  //
  // next values of the burst state and of the access stage
  always_comb begin
    state_nxt = state_r;
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    load_by_proc_nxt = 1'b0;
    acc_addr_nxt = acc_addr_r;
    acc_rd_nxt = 1'b0;
    acc_lanes_nxt = pbss_pkg::LANES_NONE;
    acc_data_nxt = acc_data_r;
    case (state_r)
      pbss_pkg::PBSS_IDLE: begin
        if (load_any && selected) begin
          state_nxt = pbss_pkg::PBSS_ACTIVE;
          base_nxt = addr_in;
          cnt_nxt = pbss_pkg::CNT_RST;
          load_by_proc_nxt = load_proc;
          acc_addr_nxt = addr_in;
          // a processor strobe cycle is always a read, write follows later
          if (!load_proc && wr_any) begin
            acc_lanes_nxt = wr_lanes;
            acc_data_nxt = dq_in;
          end else begin
            acc_rd_nxt = 1'b1;
          end
        end
      end
      pbss_pkg::PBSS_ACTIVE: begin
        if (sleep_request_in) begin
          state_nxt = pbss_pkg::PBSS_IDLE;
        end else if (load_any && !selected) begin
          state_nxt = pbss_pkg::PBSS_IDLE;
        end else if (load_any) begin
          base_nxt = addr_in;
          cnt_nxt = pbss_pkg::CNT_RST;
          load_by_proc_nxt = load_proc;
          acc_addr_nxt = addr_in;
          if (!load_proc && wr_any) begin
            acc_lanes_nxt = wr_lanes;
            acc_data_nxt = dq_in;
          end else begin
            acc_rd_nxt = 1'b1;
          end
        end else begin
          // continue: upper bits held, only the low two move
          cnt_nxt = step_cnt;
          acc_addr_nxt = {base_r[pbss_pkg::ADDR_W-1:pbss_pkg::BURST_W], low_bits};
          if (wr_any) begin
            acc_lanes_nxt = wr_lanes;
            acc_data_nxt = dq_in;
          end else begin
            acc_rd_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = pbss_pkg::PBSS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register the burst state and the access stage
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= pbss_pkg::PBSS_IDLE;
      base_r <= pbss_pkg::ADDR_RST;
      cnt_r <= pbss_pkg::CNT_RST;
      load_by_proc_r <= 1'b0;
      acc_addr_r <= pbss_pkg::ADDR_RST;
      acc_rd_r <= 1'b0;
      acc_lanes_r <= pbss_pkg::LANES_NONE;
      acc_data_r <= pbss_pkg::DATA_RST;
    end else begin
      state_r <= state_nxt;
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      load_by_proc_r <= load_by_proc_nxt;
      acc_addr_r <= acc_addr_nxt;
      acc_rd_r <= acc_rd_nxt;
      acc_lanes_r <= acc_lanes_nxt;
      acc_data_r <= acc_data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the array write needs nothing from the controller after the edge that
  // registered it; lanes not picked keep their old contents, so a partial
  // write never disturbs neighbouring bytes of the same word
  // the array has no reset on purpose: clearing a large store would cost a
  // long sequence that the device never performs
  //
  // self-timed array write, one edge after the controls were registered
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < pbss_pkg::LANES; i++) begin
      if (acc_lanes_r[i]) begin
        mem[acc_addr_r][i*pbss_pkg::LANE_W +: pbss_pkg::LANE_W] <=
          acc_data_r[i*pbss_pkg::LANE_W +: pbss_pkg::LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the read stage only follows an access that asked for a read; a write
  // access leaves the last read word standing, so the pins hold their value
  // while the drivers are off and nothing toggles needlessly
  //
  // next values of the read pipeline
  always_comb begin
    rd_valid_nxt = acc_rd_r;
    rd_data_nxt = rd_data_r;
    if (acc_rd_r) begin
      rd_data_nxt = mem[acc_addr_r];
    end
    dout_valid_nxt = rd_valid_r;
    dout_nxt = dout_r;
    if (rd_valid_r) begin
      dout_nxt = rd_data_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register the read pipeline
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_r <= pbss_pkg::DATA_RST;
      rd_valid_r <= 1'b0;
      dout_r <= pbss_pkg::DATA_RST;
      dout_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      dout_r <= dout_nxt;
      dout_valid_r <= dout_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the driver enable is the one output not taken straight from a flop:
  // output enable and sleep must act without waiting for a clock edge, so
  // they gate the registered valid bit directly; the data itself always
  // comes from the output register, so the word on the pins never glitches
  // while the enable is switched
  //
  // pin drive: data from the output register, enable gated without the clock
  assign dq_out = dout_r;
  assign dq_oe_out = dout_valid_r & ~out_enable_n_in & ~sleep_request_in;

endmodule

// *** pbss_props.sv ***
// assertions on the pins of the burst memory port
`timescale 1ns/1ps
module pbss_props (
  // every pin of the port
  input wire logic core_clk_in, rstn_in,
  input wire logic [pbss_pkg::ADDR_W-1:0] addr_in,
  input wire logic proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, burst_advance_n_in,
  input wire logic chip_sel_pipe_n_in, chip_sel_depth_hi_in, chip_sel_depth_n_in,
  input wire logic [pbss_pkg::LANES-1:0] byte_lane_write_n_in,
  input wire logic byte_write_qual_n_in, all_bytes_write_n_in,
  input wire logic [pbss_pkg::DATA_W-1:0] dq_in, dq_out,
  input wire logic burst_order_in, out_enable_n_in, sleep_request_in, dq_oe_out
);
  logic sel, ld, wr, ld_rd, cont_rd, en, maybe_rd;
  // request decoded at each edge
  assign sel = !chip_sel_pipe_n_in && chip_sel_depth_hi_in && !chip_sel_depth_n_in;
  assign ld = !ctrl_addr_strobe_n_in || (!proc_addr_strobe_n_in && !chip_sel_pipe_n_in);
  assign wr = !all_bytes_write_n_in || (!byte_write_qual_n_in && !(&byte_lane_write_n_in));
  assign ld_rd = ld && sel && !sleep_request_in && !wr;
  assign cont_rd = !ld && !burst_advance_n_in && !wr && !sleep_request_in;
  assign en = !out_enable_n_in && !sleep_request_in;
  assign maybe_rd = !wr || !proc_addr_strobe_n_in; // superset of edges that may read
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  sleep_gate_a: assert property (sleep_request_in |-> !dq_oe_out)
    else $error("drivers on while asleep");
  oe_gate_a: assert property (out_enable_n_in |-> !dq_oe_out)
    else $error("drivers on with output enable off");
  read_lat_a: assert property (ld_rd ##1 !sleep_request_in [*2] ##1 en |-> dq_oe_out)
    else $error("first read beat missing two edges after load");
  burst_beats_a: assert property (ld_rd ##1 cont_rd [*3] ##1 en [*3] |-> dq_oe_out)
    else $error("fourth burst beat missing");
  deselect_a: assert property (ld && !sel ##1 !ld [*2] |=> !dq_oe_out)
    else $error("port still driving after deselect");
  sleep_block_a: assert property
    (sleep_request_in ##1 (!ld || sleep_request_in) [*2] |=> !dq_oe_out)
    else $error("load accepted during sleep");
  oe_cause_a: assert property (dq_oe_out |-> $past(maybe_rd, 3))
    else $error("drivers on without a read three edges back");
  dq_hold_a: assert property ($changed(dq_out) |-> $past(maybe_rd, 3))
    else $error("read data changed without a read");
  cover property (ld_rd ##1 cont_rd [*3]);
  cover property (ld && sel && wr);
  cover property (ld && !sel);
endmodule
bind pbss_port pbss_props u_props (.*);

// *** tb_top.sv ***
// self-checking bench for the burst memory port
`timescale 1ns/1ps
module tb_top;
  logic core_clk_in, rstn_in, burst_order_in, out_enable_n_in, sleep_request_in, dq_oe_out;
  logic proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, burst_advance_n_in, chip_sel_pipe_n_in;
  logic chip_sel_depth_hi_in, chip_sel_depth_n_in, byte_write_qual_n_in, all_bytes_write_n_in;
  logic [pbss_pkg::ADDR_W-1:0] addr_in;
  logic [pbss_pkg::LANES-1:0] byte_lane_write_n_in;
  logic [pbss_pkg::DATA_W-1:0] dq_in, dq_out;
  logic [pbss_pkg::DATA_W-1:0] mem [logic [pbss_pkg::ADDR_W-1:0]];
  logic [15:0] rnd;
  logic [17:0] gb [2];
  logic [5:0] wt [5] = '{6'h2e, 6'h2c, 6'h20, 6'h30, 6'h25};
  logic [2:0] ds [4] = '{3'h6, 3'h0, 3'h3, 3'h7};
  int n_mismatch, samples_checked;
  pbss_port uut (.*);
  pbss_host u_host (.clk_in(core_clk_in), .addr_out(addr_in), .ps_n_out(proc_addr_strobe_n_in),
    .cs_n_out(ctrl_addr_strobe_n_in), .adv_n_out(burst_advance_n_in),
    .pipe_n_out(chip_sel_pipe_n_in), .hi_out(chip_sel_depth_hi_in), .dn_out(chip_sel_depth_n_in),
    .lane_n_out(byte_lane_write_n_in), .wq_n_out(byte_write_qual_n_in),
    .gw_n_out(all_bytes_write_n_in), .d_out(dq_in));
  ////////////////////////////////////////////////////////////////
  // pseudo-random step, expected burst address and written word
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [19:0] bad(input logic [19:0] a, input logic [1:0] c, input logic il);
    return {a[19:2], il ? a[1:0] ^ c : a[1:0] + c};
  endfunction
  function automatic logic [35:0] mrg(input logic [35:0] o, d, input logic [5:0] wc);
    for (int l = 0; l < 4; l++)
      if (!wc[5] || (!wc[4] && !wc[l])) o[l*9+:9] = d[l*9+:9];
    return o;
  endfunction
  // comparisons and the verdict
  task automatic chk_d(input logic [35:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, e);
    chk_d({35'h0, g}, {35'h0, e});
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bus operations
  task automatic idle();
    u_host.drive(2'h0, 1'b0, 6'h3f, 20'h00000, 36'h0, 3'h2);
  endtask
  task automatic wr(input logic [19:0] a, input logic [35:0] d, input logic [5:0] wc);
    u_host.drive(2'h1, 1'b0, wc, a, d, 3'h2);
    mem[a] = mrg(mem[a], d, wc);
  endtask
  task automatic rd(input logic [19:0] a, input logic [1:0] ld, input logic il, input logic [2:0] d);
    for (int i = 0; i < 8; i++) begin
      u_host.drive(i == 0 ? ld : (i == 4 ? 2'h1 : 2'h0), i > 0 && i < 4, 6'h3f, a, 36'h0,
        i == 4 ? d : 3'h2);
      if (i >= 3 && i < 7) chk_d(dq_out, mem[bad(a, 2'(i - 3), il)]);
      if (i >= 3) chk_b(dq_oe_out, i < 7);
      if (i == 5 || i == 6) begin
        {out_enable_n_in, sleep_request_in} = i == 5 ? 2'h2 : 2'h1;
        #1 chk_b(dq_oe_out, 1'b0);
        {out_enable_n_in, sleep_request_in} = 2'h0;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  // main sequence
  initial begin
    {rstn_in, out_enable_n_in, sleep_request_in, burst_order_in} = 4'h1;
    n_mismatch = 0;
    samples_checked = 0;
    rnd = 16'h06ba;
    gb[0] = 18'h3ffff;
    gb[1] = {2'h0, nx(rnd)};
    repeat (20) @(negedge core_clk_in);
    rstn_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd = nx(rnd);
      wr({gb[i/4], 2'(i)}, {rnd, ~rnd, rnd[3:0]}, i == 0 ? 6'h05 : 6'h1f);
    end
    $display("fill done");
    for (int k = 0; k < 5; k++) begin
      rnd = nx(rnd);
      wr({gb[0], 2'(k)}, {~rnd, rnd, rnd[7:4]}, wt[k]);
    end
    $display("lane writes done");
    for (int k = 0; k < 4; k++) begin
      burst_order_in = k[0];
      idle();
      idle();
      rnd = nx(rnd);
      rd({gb[k[1] ^ k[0]], rnd[1:0]}, k[1] ? 2'h2 : 2'h1, k[0], ds[k]);
    end
    $display("bursts done");
    sleep_request_in = 1'b1;
    u_host.drive(2'h1, 1'b0, 6'h3f, {gb[0], 2'h0}, 36'h0, 3'h2);
    idle();
    sleep_request_in = 1'b0;
    repeat (3) begin
      idle();
      chk_b(dq_oe_out, 1'b0);
    end
    $display("sleep done");
    wrap_up();
  end
endmodule
